// ==== sim/lpbc_prbs_src.sv ====
module lpbc_prbs_src
    import lpbc_pkg::*;
(
    input  wire logic                        clk_i,
    input  wire logic                        nrst_i,
    input  wire logic                        hold_i,
    input  wire logic                        flip_i,
    output lpbc_pkg::lpbc_word_t [7:0]       data_o,
    output logic                             valid_o
);
    logic       [6:0] hist;
    logic       [6:0] h;
    lpbc_word_t       w;
    // prbs7 word, bit0 sent first; lane 0 may carry one bad bit
    always_comb
    begin
        h = hist;
        for (int i = 0; i < 40; i++)
        begin
            w[i] = h[6] ^ h[5];
            h = {h[5:0], w[i]};
        end
        for (int l = 0; l < 8; l++)
            data_o[l] = w ^ {39'h0, flip_i && l == 0};
        valid_o = !hold_i;
    end
    // history steps once per word, frozen while held
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
            hist <= 7'h7F;
        else if (!hold_i)
            hist <= h;
endmodule

// ==== sim/tb_lpbc_top.sv ====
module tb_lpbc_top import lpbc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic             clk_sys_i = 1'b0;
    logic             nrst_i = 1'b0;
    logic [9:0]       avs_address_i = '0;
    logic             avs_read_i = 1'b0;
    logic             avs_write_i = 1'b0;
    logic [31:0]      avs_writedata_i = '0;
    logic [31:0]      avs_readdata_o;
    logic             avs_waitrequest_o;
    lpbc_word_t [7:0] lane_data;
    logic             lane_valid;
    logic [1:0]       sync_err_req_i = 2'b00;
    logic [1:0]       link_sync_output_n_o;
    logic             irq_o;
    logic             hold = 1'b0;
    logic             flip = 1'b0;
    logic [7:0]       q;
    int               n_mismatch = 0;
    int               check_count = 0;
    int               cyc = 0;
    int               low_cnt;
    always #25 clk_sys_i = ~clk_sys_i;
    lpbc_prbs_src lpbc_prbs_src_i (.clk_i(clk_sys_i), .nrst_i(nrst_i), .hold_i(hold),
        .flip_i(flip), .data_o(lane_data), .valid_o(lane_valid));
    lpbc_top lpbc_top_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .lane_data_i(lane_data), .lane_valid_i(lane_valid), .sync_err_req_i(sync_err_req_i),
        .link_sync_output_n_o(link_sync_output_n_o), .irq_o(irq_o));
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        // only the hang guard ends a wait that never completes
        do
            @(posedge clk_sys_i);
        while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o[7:0];
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic rdc(input logic [9:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    // corrupt one bit of lane 0 in n words
    task automatic flip_word(input int n);
        flip <= 1'b1;
        repeat (n) @(posedge clk_sys_i);
        flip <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    endtask
    // hang guard
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rdc(10'h31D, 8'hFF);
        rdc(10'h312, 8'h00);
        rdc(10'h300, 8'h00);
        for (int p = 0; p < 4; p++)
        begin
            bus(1'b1, 10'h316, 8'(p << 2));
            rdc(10'h316, 8'(p << 2));
        end
        bus(1'b1, 10'h317, 8'h01);
        bus(1'b1, 10'h319, 8'h00);
        rdc(10'h317, 8'h01);
        bus(1'b1, 10'h331, 8'h01);
        bus(1'b1, 10'h315, 8'h01);
        bus(1'b1, 10'h316, 8'h02);
        repeat (8) @(posedge clk_sys_i);
        rdc(10'h31A, 8'h00);
        flip_word(2);
        rdc(10'h31A, 8'h06);
        rdc(10'h31B, 8'h00);
        rdc(10'h31D, 8'hFE);
        chk({7'h0, irq_o}, 8'h01);
        rdc(10'h330, 8'h01);
        @(posedge clk_sys_i);
        chk({7'h0, irq_o}, 8'h00);
        bus(1'b1, 10'h316, 8'h12);
        rdc(10'h31A, 8'h00);
        bus(1'b1, 10'h316, 8'h00);
        flip_word(3);
        rdc(10'h31A, 8'h06);
        bus(1'b1, 10'h316, 8'h01);
        bus(1'b1, 10'h316, 8'h00);
        rdc(10'h31A, 8'h00);
        bus(1'b1, 10'h315, 8'h00);
        bus(1'b1, 10'h316, 8'h02);
        flip_word(3);
        rdc(10'h31A, 8'h00);
        bus(1'b1, 10'h315, 8'h01);
        bus(1'b1, 10'h316, 8'h00);
        hold <= 1'b1;
        bus(1'b1, 10'h31E, 8'h01);
        for (int i = 0; i < 5; i++)
            rdc(10'h31F + 10'(i), lane_data[0][8*i+:8]);
        hold <= 1'b0;
        // error-triggered capture: word after the bad one, frozen by hold
        bus(1'b1, 10'h31E, 8'h02);
        bus(1'b1, 10'h316, 8'h02);
        repeat (4) @(posedge clk_sys_i);
        flip <= 1'b1;
        @(posedge clk_sys_i);
        flip <= 1'b0;
        hold <= 1'b1;
        @(posedge clk_sys_i);
        for (int i = 0; i < 5; i++)
            rdc(10'h31F + 10'(i), lane_data[0][8*i+:8]);
        rdc(10'h31A, 8'h03);
        hold <= 1'b0;
        bus(1'b1, 10'h312, 8'h30);
        sync_err_req_i <= 2'b11;
        @(posedge clk_sys_i);
        sync_err_req_i <= 2'b00;
        low_cnt = 0;
        repeat (20)
        begin
            @(posedge clk_sys_i);
            if (link_sync_output_n_o === 2'b00)
                low_cnt++;
        end
        chk(8'(low_cnt), 8'h07);
        tally_and_finish();
    end
endmodule

// ==== verilog/lpbc_if.sv ====
// per-lane checker control and result
interface lpbc_chk_if;
    logic                 clk;
    logic                 nrst;
    logic                 active;
    logic                 clear;
    logic                 run;
    logic                 valid;
    lpbc_pkg::lpbc_word_t data;
    lpbc_pkg::lpbc_pat_t  pattern;
    logic [23:0]          threshold;
    logic [23:0]          err_cnt;
    logic                 pass;
    logic                 bit_err;
    modport ctrl (output clk, nrst, active, clear, run, valid, data, pattern, threshold,
                  input err_cnt, pass, bit_err);
    modport lane (input clk, nrst, active, clear, run, valid, data, pattern, threshold,
                  output err_cnt, pass, bit_err);
endinterface

// shared error-pulse generator for both link sync outputs
interface lpbc_sync_if;
    logic       clk;
    logic       nrst;
    logic       ce;
    logic [3:0] code;
    logic [1:0] req;
    logic [1:0] sync_n;
    modport ctrl (output clk, nrst, ce, code, req, input sync_n);
    modport gen  (input clk, nrst, ce, code, req, output sync_n);
endinterface

// ==== verilog/lpbc_lane_chk.sv ====
module lpbc_lane_chk
(
    lpbc_chk_if.lane c
);
    import lpbc_pkg::*;

    lpbc_lane_st_t state;
    logic [30:0]   hist;
    logic [5:0]    word_errs;
    logic [30:0]   next_hist;
    logic [24:0]   sum;
    logic [23:0]   next_cnt;

    // ----------------------------------------------------------------
    // self-synchronising prbs step over one 40-bit word, lsb first
    // ----------------------------------------------------------------
    function automatic logic [36:0] prbs_step(input logic [30:0] h, input lpbc_word_t d,
                                              input lpbc_pat_t pat);
        logic [30:0] hh;
        logic [5:0]  n;
        logic        pred;
        hh = h;
        n  = 6'h00;
        for (int i = 0; i < 40; i++)
        begin
            case (pat)
                2'h0:    pred = hh[6] ^ hh[5];
                2'h1:    pred = hh[14] ^ hh[13];
                2'h2:    pred = hh[30] ^ hh[27];
                default: pred = d[i];
            endcase
            n  = n + {5'h00, d[i] ^ pred};
            hh = {hh[29:0], d[i]};
        end
        return {n, hh};
    endfunction

    // error count of the current word, saturating accumulation
    always_comb
    begin
        {word_errs, next_hist} = prbs_step(hist, c.data, c.pattern);
        sum      = {1'b0, c.err_cnt} + {19'h0, word_errs};
        next_cnt = sum[24] ? 24'hFFFFFF : sum[23:0];
    end

    // ----------------------------------------------------------------
    // lane state, counter and pass flag
    // ----------------------------------------------------------------
    always_ff @(posedge c.clk or negedge c.nrst)
    begin
        if (!c.nrst)
        begin
            state     <= LST_IDLE;
            hist      <= 31'h00000000;
            c.err_cnt <= 24'h000000;
            c.pass    <= 1'b1;
            c.bit_err <= 1'b0;
        end
        else if (c.active)
        begin
            c.bit_err <= 1'b0;
            if (c.clear)
            begin
                state     <= LST_IDLE;
                c.err_cnt <= 24'h000000;
                c.pass    <= 1'b1;
            end
            else
            begin
                case (state)
                    LST_IDLE:
                    begin
                        if (c.run)
                            state <= LST_SEED;
                    end
                    LST_SEED:
                    begin
                        if (!c.run)
                            state <= LST_IDLE;
                        else if (c.valid)
                        begin
                            hist  <= next_hist;
                            state <= LST_CHECK;
                        end
                    end
                    LST_CHECK:
                    begin
                        if (!c.run)
                            state <= LST_IDLE;
                        else if (c.valid)
                        begin
                            hist      <= next_hist;
                            c.err_cnt <= next_cnt;
                            c.bit_err <= (word_errs != 6'h00);
                            if (next_cnt > c.threshold)
                                c.pass <= 1'b0;
                        end
                    end
                    default: state <= LST_IDLE;
                endcase
            end
        end
    end

    property p_fail_cause;
        @(posedge c.clk) disable iff (!c.nrst)
        $fell(c.pass) |-> (c.err_cnt > c.threshold);
    endproperty
    a_fail_cause: assert property (p_fail_cause)
        else $error("pass flag dropped with count not above threshold");
endmodule

// ==== verilog/lpbc_pkg.sv ====
package lpbc_pkg;
    typedef logic [39:0] lpbc_word_t;
    typedef logic [1:0]  lpbc_pat_t;
    typedef enum {LST_IDLE, LST_SEED, LST_CHECK} lpbc_lane_st_t;
endpackage

// ==== verilog/lpbc_regs.svh ====
`ifndef LPBC_REGS_SVH
`define LPBC_REGS_SVH
// ----------------------------------------------------------------
// register indexes (byte address = 4 * index)
// ----------------------------------------------------------------
`define LPBC_IDX_SYNC_PULSE   10'h312
`define LPBC_IDX_CLK_EN       10'h315
`define LPBC_IDX_CTRL         10'h316
`define LPBC_IDX_THR_LOW      10'h317
`define LPBC_IDX_THR_MID      10'h318
`define LPBC_IDX_THR_HIGH     10'h319
`define LPBC_IDX_CNT_LOW      10'h31A
`define LPBC_IDX_CNT_MID      10'h31B
`define LPBC_IDX_CNT_HIGH     10'h31C
`define LPBC_IDX_PASS         10'h31D
`define LPBC_IDX_SNAP_CTRL    10'h31E
`define LPBC_IDX_SNAP_B0      10'h31F
`define LPBC_IDX_SNAP_B4      10'h323
`define LPBC_IDX_IRQ_STAT     10'h330
`define LPBC_IDX_IRQ_MASK     10'h331
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define LPBC_POS_PULSE_CODE   4
`define LPBC_POS_SEL          4
`define LPBC_POS_PAT          2
`define LPBC_POS_RUN          1
`define LPBC_POS_CLR          0
`define LPBC_POS_GRAB_MODE    1
`define LPBC_POS_GRAB_CMD     0
`define LPBC_POS_IRQ_SNAP     8
`define LPBC_RST_BYTE         8'h00
`define LPBC_RST_PASS         8'hFF
`define LPBC_RST_THR          24'h000000
`endif

// ==== verilog/lpbc_sync_pulse.sv ====
module lpbc_sync_pulse
(
    lpbc_sync_if.gen s
);
    import lpbc_pkg::*;

    logic [1:0][4:0] left;
    logic [4:0]      low_len;
    logic [3:0]      code_q;

    // ----------------------------------------------------------------
    // low pulse of 2*code+1 half-pclk cycles, one code for both links
    // ----------------------------------------------------------------
    always_ff @(posedge s.clk or negedge s.nrst)
    begin
        if (!s.nrst)
        begin
            s.sync_n <= 2'h3;
            left     <= '0;
        end
        else if (s.ce)
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (s.sync_n[i] && s.req[i])
                begin
                    s.sync_n[i] <= 1'b0;
                    left[i]     <= {s.code, 1'b0};
                end
                else if (!s.sync_n[i])
                begin
                    if (left[i] == 5'h00)
                        s.sync_n[i] <= 1'b1;
                    else
                        left[i] <= left[i] - 5'h01;
                end
            end
        end
    end

    // helper: measured low length of link 0
    always_ff @(posedge s.clk or negedge s.nrst)
    begin
        if (!s.nrst)
        begin
            low_len <= 5'h00;
            code_q  <= 4'h0;
        end
        else if (s.ce)
        begin
            if (s.sync_n[0] && s.req[0])
            begin
                low_len <= 5'h00;
                code_q  <= s.code;
            end
            else if (!s.sync_n[0])
                low_len <= low_len + 5'h01;
        end
    end

    property p_pulse_len;
        @(posedge s.clk) disable iff (!s.nrst)
        $rose(s.sync_n[0]) |-> (low_len == {code_q, 1'b1});
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("sync low pulse length wrong");

    property p_shared_len;
        @(posedge s.clk) disable iff (!s.nrst)
        (s.ce && (s.req == 2'h3) && (s.sync_n == 2'h3)) |=> (s.sync_n[0] == s.sync_n[1])
        [*1] ##1 (!s.ce || (s.sync_n[0] == s.sync_n[1]));
    endproperty
    a_shared_len: assert property (p_shared_len)
        else $error("links use different pulse lengths");
endmodule

// ==== verilog/lpbc_top.sv ====
// Register access over Avalon-MM was left to the implementer.
`include "lpbc_regs.svh"

// Behaviour
// - sync low for (0.5 + code) pclk
// - one duration code for both links
// - test logic frozen while clock enable zero
// - lane select picks reported error count
// - pattern code selects prbs7/15/31
// - checking runs while run bit set
// - clear bit resets state and counters
// - 24-bit threshold over three bytes
// - selected count readable as three bytes
// - per-lane pass bits, all ones reset
// - capture on command or on error
// - command rising edge captures one lane
// - 40-bit snapshot as five bytes
module lpbc_top
#(
    parameter int LANES = 8
)
(
    input  wire logic                                clk_sys_i,
    input  wire logic                                nrst_i,
    input  wire logic                                ce_i,
    input  wire logic [9:0]                          avs_address_i,
    input  wire logic                                avs_read_i,
    input  wire logic                                avs_write_i,
    input  wire logic [31:0]                         avs_writedata_i,
    input  wire logic [3:0]                          avs_byteenable_i,
    output logic      [31:0]                         avs_readdata_o,
    output logic                                     avs_waitrequest_o,
    input  wire lpbc_pkg::lpbc_word_t [LANES-1:0]    lane_data_i,
    input  wire logic                                lane_valid_i,
    input  wire logic [1:0]                          sync_err_req_i,
    output logic      [1:0]                          link_sync_output_n_o,
    output logic                                     irq_o
);
    import lpbc_pkg::*;

    logic [7:0]              pulse_cfg;
    logic [7:0]              clk_gate_reg;
    logic [6:0]              ctrl;
    logic [23:0]             error_threshold_bits;
    logic [1:0]              snap_ctrl;
    logic                    grab_q;
    lpbc_word_t              captured_lane_word;
    logic [8:0]              irq_mask;
    logic [8:0]              irq_stat;
    logic [7:0]              pass_q;
    logic                    ack;
    logic [31:0]             rdata;
    logic                    wr_go;
    logic                    rd_go;
    logic                    lane_test_clock_gate;
    logic                    test_active;
    logic [2:0]              count_lane_select;
    logic                    capture_trigger_select;
    logic                    capture_command;
    logic [LANES-1:0][23:0]  lane_cnt;
    logic [7:0]              lane_pass_flags;
    logic [LANES-1:0]        lane_err;
    logic [23:0]             error_count_bits;
    logic                    snap_take;
    logic [8:0]              events;
    logic [7:0]              next_pass_flags;

    // ----------------------------------------------------------------
    // field views
    // ----------------------------------------------------------------
    assign lane_test_clock_gate   = clk_gate_reg[0];
    assign test_active            = ce_i && lane_test_clock_gate;
    assign count_lane_select      = ctrl[`LPBC_POS_SEL +: 3];
    assign capture_trigger_select = snap_ctrl[`LPBC_POS_GRAB_MODE];
    assign capture_command        = snap_ctrl[`LPBC_POS_GRAB_CMD];
    assign error_count_bits       = lane_cnt[count_lane_select];

    // ----------------------------------------------------------------
    // lane checkers
    // ----------------------------------------------------------------
    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
        lpbc_chk_if chk ();
        assign chk.clk       = clk_sys_i;
        assign chk.nrst      = nrst_i;
        assign chk.active    = test_active;
        assign chk.clear     = ctrl[`LPBC_POS_CLR];
        assign chk.run       = ctrl[`LPBC_POS_RUN];
        assign chk.valid     = lane_valid_i;
        assign chk.data      = lane_data_i[g];
        assign chk.pattern   = ctrl[`LPBC_POS_PAT +: 2];
        assign chk.threshold = error_threshold_bits;
        assign lane_cnt[g]   = chk.err_cnt;
        assign lane_err[g]   = chk.bit_err;
        assign lane_pass_flags[g] = chk.pass;
        lpbc_lane_chk u_chk (
            .c (chk.lane)
        );
    end

    // ----------------------------------------------------------------
    // sync error pulse generator
    // ----------------------------------------------------------------
    lpbc_sync_if sif ();
    assign sif.clk  = clk_sys_i;
    assign sif.nrst = nrst_i;
    assign sif.ce   = ce_i;
    assign sif.code = pulse_cfg[`LPBC_POS_PULSE_CODE +: 4];
    assign sif.req  = sync_err_req_i;
    assign link_sync_output_n_o = sif.sync_n;
    lpbc_sync_pulse u_sync (
        .s (sif.gen)
    );

    // ----------------------------------------------------------------
    // avalon slave: one wait cycle, then completion
    // ----------------------------------------------------------------
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
    assign wr_go = ce_i && avs_write_i && ack && avs_byteenable_i[0];
    assign rd_go = ce_i && avs_read_i && ack;
    assign avs_readdata_o = rdata;

    // read mux, combinational, driven straight onto avs_readdata_o
    always_comb
    begin
        case (avs_address_i)
            `LPBC_IDX_SYNC_PULSE: rdata = {24'h000000, pulse_cfg};
            `LPBC_IDX_CLK_EN:     rdata = {24'h000000, clk_gate_reg};
            `LPBC_IDX_CTRL:       rdata = {25'h0, ctrl};
            `LPBC_IDX_THR_LOW:    rdata = {24'h000000, error_threshold_bits[7:0]};
            `LPBC_IDX_THR_MID:    rdata = {24'h000000, error_threshold_bits[15:8]};
            `LPBC_IDX_THR_HIGH:   rdata = {24'h000000, error_threshold_bits[23:16]};
            `LPBC_IDX_CNT_LOW:    rdata = {24'h000000, error_count_bits[7:0]};
            `LPBC_IDX_CNT_MID:    rdata = {24'h000000, error_count_bits[15:8]};
            `LPBC_IDX_CNT_HIGH:   rdata = {24'h000000, error_count_bits[23:16]};
            `LPBC_IDX_PASS:       rdata = {24'h000000, lane_pass_flags};
            `LPBC_IDX_SNAP_CTRL:  rdata = {30'h0, snap_ctrl};
            `LPBC_IDX_IRQ_STAT:   rdata = {23'h0, irq_stat};
            `LPBC_IDX_IRQ_MASK:   rdata = {23'h0, irq_mask};
            default:
            begin
                if (avs_address_i >= `LPBC_IDX_SNAP_B0 && avs_address_i <= `LPBC_IDX_SNAP_B4)
                    rdata = {24'h000000,
                             captured_lane_word[{avs_address_i[2:0] - 3'h7, 3'h0} +: 8]};
                else
                    rdata = 32'h00000000;
            end
        endcase
    end

    // handshake state
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            ack <= 1'b0;
        else if (ce_i)
            ack <= (avs_read_i || avs_write_i) && !ack;
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pulse_cfg            <= `LPBC_RST_BYTE;
            clk_gate_reg         <= `LPBC_RST_BYTE;
            ctrl                 <= 7'h00;
            error_threshold_bits <= `LPBC_RST_THR;
            snap_ctrl            <= 2'h0;
            irq_mask             <= 9'h000;
        end
        else if (wr_go)
        begin
            case (avs_address_i)
                `LPBC_IDX_SYNC_PULSE: pulse_cfg <= avs_writedata_i[7:0];
                `LPBC_IDX_CLK_EN:     clk_gate_reg <= avs_writedata_i[7:0];
                `LPBC_IDX_CTRL:       ctrl <= avs_writedata_i[6:0];
                `LPBC_IDX_THR_LOW:    error_threshold_bits[7:0] <= avs_writedata_i[7:0];
                `LPBC_IDX_THR_MID:    error_threshold_bits[15:8] <= avs_writedata_i[7:0];
                `LPBC_IDX_THR_HIGH:   error_threshold_bits[23:16] <= avs_writedata_i[7:0];
                `LPBC_IDX_SNAP_CTRL:  snap_ctrl <= avs_writedata_i[1:0];
                `LPBC_IDX_IRQ_MASK:   irq_mask <= avs_writedata_i[8:0];
                default:              irq_mask <= irq_mask;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // snapshot capture
    // ----------------------------------------------------------------
    assign snap_take = capture_trigger_select ? lane_err[count_lane_select]
                                              : (capture_command && !grab_q);

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            grab_q             <= 1'b0;
            captured_lane_word <= '0;
        end
        else if (ce_i)
        begin
            grab_q <= capture_command;
            if (snap_take)
                captured_lane_word <= lane_data_i[count_lane_select];
        end
    end

    // ----------------------------------------------------------------
    // interrupts: lane failure and snapshot, clear on read
    // ----------------------------------------------------------------
    assign next_pass_flags = lane_pass_flags;
    assign events = {snap_take, pass_q & ~next_pass_flags};
    assign irq_o  = |(irq_stat & irq_mask);

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pass_q   <= `LPBC_RST_PASS;
            irq_stat <= 9'h000;
        end
        else if (ce_i)
        begin
            pass_q <= lane_pass_flags;
            if (rd_go && avs_address_i == `LPBC_IDX_IRQ_STAT)
                irq_stat <= events; // new events win over the clear
            else
                irq_stat <= irq_stat | events;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_gate_freeze;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (!lane_test_clock_gate && !wr_go) |=> $stable(lane_cnt) && $stable(lane_pass_flags);
    endproperty
    a_gate_freeze: assert property (p_gate_freeze)
        else $error("lane test state moved while gated");

    property p_count_read;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (rd_go && avs_address_i == `LPBC_IDX_CNT_LOW)
        |-> (avs_readdata_o[7:0] == lane_cnt[count_lane_select][7:0]);
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("count read does not follow lane select");

    property p_run_stop;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (!ctrl[`LPBC_POS_RUN] && !wr_go) ##1 !ctrl[`LPBC_POS_RUN] |=> $stable(lane_cnt);
    endproperty
    a_run_stop: assert property (p_run_stop)
        else $error("counting while stopped");

    property p_clear;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (test_active && ctrl[`LPBC_POS_CLR])
        |=> (lane_cnt == '0) && (lane_pass_flags == 8'hFF);
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not reset counters and pass flags");

    property p_thr_write;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_go && avs_address_i == `LPBC_IDX_THR_HIGH)
        |=> (error_threshold_bits[23:16] == $past(avs_writedata_i[7:0]));
    endproperty
    a_thr_write: assert property (p_thr_write)
        else $error("threshold high byte not stored");

    property p_grab_cmd;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && !capture_trigger_select && capture_command && !grab_q)
        |=> (captured_lane_word == $past(lane_data_i[count_lane_select]));
    endproperty
    a_grab_cmd: assert property (p_grab_cmd)
        else $error("command capture missed");

    property p_grab_err;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && capture_trigger_select && lane_err[count_lane_select])
        |=> (captured_lane_word == $past(lane_data_i[count_lane_select]));
    endproperty
    a_grab_err: assert property (p_grab_err)
        else $error("error capture missed");

    property p_snap_top;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (rd_go && avs_address_i == `LPBC_IDX_SNAP_B4)
        |-> (avs_readdata_o == {24'h000000, captured_lane_word[39:32]});
    endproperty
    a_snap_top: assert property (p_snap_top)
        else $error("snapshot top byte wrong");

    property p_irq_level;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ce_i && |events) |=> irq_stat != 9'h000;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("event not recorded");
endmodule
